// ---- aps_pkg.sv ----
// shared constants and types for the arbitrary pulse segment registers
package aps_pkg;

  // ********************************************************
  // widths and counts
  // ********************************************************
  localparam int ADDR_W    = 5;   // register address width
  localparam int DATA_W    = 8;   // register data width
  localparam int MAG_W     = 6;   // magnitude part of a code
  localparam int SEG_COUNT = 8;   // segments per pulse
  localparam int OWN_REGS  = 3;   // registers held here

  // ********************************************************
  // register offsets, field positions, reset values
  // ********************************************************
  localparam logic [4:0] SEG_TWO_ADDR   = 5'h09;
  localparam logic [4:0] SEG_THREE_ADDR = 5'h0A;
  localparam logic [4:0] SEG_FOUR_ADDR  = 5'h0B;
  localparam int         SIGN_POS       = 6;     // polarity bit
  localparam int         MAG_MSB        = 5;     // top magnitude bit
  localparam logic [7:0] SEG_REG_RESET  = 8'h00;
  localparam logic [7:0] READ_IDLE      = 8'h00; // unmapped answer

  // segment index of each own register (0 is segment one)
  localparam logic [2:0] SEG_IDX_TWO    = 3'h1;
  localparam logic [2:0] SEG_IDX_THREE  = 3'h2;
  localparam logic [2:0] SEG_IDX_FOUR   = 3'h3;

  // ********************************************************
  // timing counts
  // ********************************************************
  localparam int SEG_CYCLES_DEF = 8;  // ref_clk cycles per segment
  localparam int PERIOD_CYCLES  = SEG_COUNT * SEG_CYCLES_DEF;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic             sign;  // polarity
    logic [MAG_W-1:0] mag;   // magnitude, lsb at bit 0
  } aps_amp_t;

  typedef struct packed {
    logic     active;  // pulse being shaped
    logic [2:0] seg;   // current segment index
    aps_amp_t amp;     // amplitude to the driver
  } aps_drive_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;   // write strobe
    logic              rd;   // read strobe
  } aps_bus_t;

  // split a register value into its signed magnitude code
  function automatic aps_amp_t aps_decode(input logic [7:0] r);
    aps_amp_t a;
    a.sign = r[SIGN_POS];
    a.mag  = r[MAG_MSB:0];
    return a;
  endfunction

endpackage

// ---- aps_preset_rom.sv ----
// fixed preset pulse shape table with registered read data
`timescale 1ns/10ps
`default_nettype none
module aps_preset_rom
  import aps_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] seg_idx,
  output var  logic [6:0] rom_q_reg
);

  // ********************************************************
  // preset shape, one code per segment
  // ********************************************************
  function automatic logic [6:0] preset_code(input logic [2:0] i);
    unique case (i)
      3'h0: preset_code = 7'h30;
      3'h1: preset_code = 7'h3F;
      3'h2: preset_code = 7'h3C;
      3'h3: preset_code = 7'h38;
      3'h4: preset_code = 7'h48;
      3'h5: preset_code = 7'h44;
      3'h6: preset_code = 7'h42;
      3'h7: preset_code = 7'h00;
    endcase
  endfunction

  logic [6:0] rom_q_next;  // looked up code

  // lookup
  always_comb
  begin
    rom_q_next = preset_code(seg_idx);
  end

  // read data register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      rom_q_reg <= 7'h00;
    else
      rom_q_reg <= rom_q_next;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_rom_latency: assert property ($past(reset_n) |-> rom_q_reg == preset_code($past(seg_idx)))
    else $error("preset data not one cycle after index");

endmodule
`default_nettype wire

// ---- aps_seg_timer.sv ----
// segment timer: eight equal segments per master clock period
`timescale 1ns/10ps
`default_nettype none
module aps_seg_timer
  import aps_pkg::*;
#(
  parameter int SEG_CYCLES = SEG_CYCLES_DEF
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  output var  logic [2:0] seg_idx_reg,
  output var  logic       seg_tick_reg,
  output var  logic       period_start_reg
);

  localparam int CW = (SEG_CYCLES > 1) ? $clog2(SEG_CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(SEG_CYCLES - 1);

  logic [CW-1:0] cnt_reg;          // cycles within a segment
  logic [CW-1:0] cnt_next;
  logic [2:0]    seg_idx_next;
  logic          seg_tick_next;    // index advanced
  logic          period_start_next;

  // ********************************************************
  // divider and segment counter
  // ********************************************************
  always_comb
  begin
    cnt_next          = cnt_reg + CW'(1);
    seg_idx_next      = seg_idx_reg;
    seg_tick_next     = 1'b0;
    period_start_next = 1'b0;
    if (cnt_reg == CNT_LAST)
    begin
      // segment over, step in ascending order
      cnt_next          = '0;
      seg_idx_next      = seg_idx_reg + 3'h1;
      seg_tick_next     = 1'b1;
      // eighth segment wraps to the first
      period_start_next = (seg_idx_reg == 3'h7);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cnt_reg          <= '0;
      seg_idx_reg      <= 3'h0;
      seg_tick_reg     <= 1'b0;
      period_start_reg <= 1'b0;
    end
    else
    begin
      cnt_reg          <= cnt_next;
      seg_idx_reg      <= seg_idx_next;
      seg_tick_reg     <= seg_tick_next;
      period_start_reg <= period_start_next;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  int seg_len_h;   // cycles since last segment start
  int per_len_h;   // cycles since last period start

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      seg_len_h <= 0;
      per_len_h <= 0;
    end
    else
    begin
      seg_len_h <= seg_tick_reg ? 1 : seg_len_h + 1;
      per_len_h <= period_start_reg ? 1 : per_len_h + 1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_seg_length: assert property (seg_tick_reg |-> seg_len_h == SEG_CYCLES)
    else $error("segment length wrong");
  a_period_length: assert property (
    period_start_reg |-> per_len_h == SEG_COUNT * SEG_CYCLES)
    else $error("period is not eight segments");
  a_seg_ascend: assert property (
    seg_tick_reg |-> seg_idx_reg == $past(seg_idx_reg) + 3'h1)
    else $error("segment index did not step by one");
  a_period_wrap: assert property (
    period_start_reg |-> seg_idx_reg == 3'h0 && seg_tick_reg)
    else $error("period start not at segment one");

  c_period: cover property (period_start_reg ##1 (!period_start_reg)[*2]);

endmodule
`default_nettype wire

// ---- aps_segment_regs.sv ----
// arbitrary pulse segment two to four registers and pulse shaper
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - arbitrary mode shapes pulse from programmed segments
// - eight segments fill one master clock period
// - segment two amplitude at 0x09 bits 6:0
// - segment three amplitude at 0x0A bits 6:0
// - segment four amplitude at 0x0B bits 6:0
// - codes are signed magnitude, bit 6 sign
module aps_segment_regs
  import aps_pkg::*;
#(
  parameter int SEG_CYCLES = SEG_CYCLES_DEF  // cycles per segment
)
(
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  input  wire aps_bus_t       bus,            // register port
  input  wire logic           arb_mode_sel,   // arbitrary mode chosen
  input  wire logic           tx_mark,        // pulse wanted next period
  input  wire aps_amp_t [7:0] other_seg_amp,  // codes held elsewhere
  output var  logic [7:0]     rdata_reg,      // read data
  output var  aps_drive_t     drive_reg       // to the line driver
);

  // ********************************************************
  // address decode
  // ********************************************************

  // slot of an address among the own registers
  function automatic logic [2:0] addr_slot(input logic [4:0] a);
    unique case (a)
      SEG_TWO_ADDR:   addr_slot = 3'b100;  // hit, slot 0
      SEG_THREE_ADDR: addr_slot = 3'b101;  // hit, slot 1
      SEG_FOUR_ADDR:  addr_slot = 3'b110;  // hit, slot 2
      default:        addr_slot = 3'b000;  // unmapped
    endcase
  endfunction

  logic [2:0] wr_slot;   // decode of the write address
  logic [2:0] rd_slot;   // decode of the read address

  // decode both strobes through one function
  always_comb
  begin
    wr_slot = addr_slot(bus.addr) & {bus.wr, 2'b11};
    rd_slot = addr_slot(bus.addr) & {bus.rd, 2'b11};
  end

  // ********************************************************
  // segment amplitude registers
  // ********************************************************
  logic [7:0] seg_reg [OWN_REGS];   // stored values
  logic [7:0] seg_next [OWN_REGS];  // next values

  genvar gi;
  generate
    for (gi = 0; gi < OWN_REGS; gi++)
    begin : g_seg
      // write when the strobe hits this slot; bit 7 kept too
      always_comb
      begin
        if (wr_slot == {1'b1, 2'(gi)})
          seg_next[gi] = bus.wdata;
        else
          seg_next[gi] = seg_reg[gi];
      end

      always_ff @(posedge ref_clk)
      begin
        if (!reset_n)
          seg_reg[gi] <= SEG_REG_RESET;
        else
          seg_reg[gi] <= seg_next[gi];
      end
    end
  endgenerate

  // ********************************************************
  // read port
  // ********************************************************
  logic [7:0] rdata_next;  // answer for the next cycle

  // data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_next = READ_IDLE;
    if (rd_slot[2])
      rdata_next = seg_reg[rd_slot[1:0]];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      rdata_reg <= READ_IDLE;
    else
      rdata_reg <= rdata_next;
  end

  // ********************************************************
  // segment timing and preset shape
  // ********************************************************
  logic [2:0] seg_idx;       // current segment
  logic       period_start;  // first cycle of segment one
  logic [6:0] preset_q;      // preset code, one cycle late

  // eight equal segments make one period
  aps_seg_timer #(
    .SEG_CYCLES (SEG_CYCLES)
  ) u_timer (
    .ref_clk          (ref_clk),
    .reset_n          (reset_n),
    .seg_idx_reg      (seg_idx),
    .seg_tick_reg     (),
    .period_start_reg (period_start)
  );

  // fixed shape used outside arbitrary mode
  aps_preset_rom u_rom (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .seg_idx   (seg_idx),
    .rom_q_reg (preset_q)
  );

  // ********************************************************
  // period state: mark and mode held for a whole period
  // ********************************************************
  logic mark_cur_reg;   // mark of the running period
  logic mark_cur_next;
  logic arb_cur_reg;    // mode of the running period
  logic arb_cur_next;

  // sample only at the period start, so a mode change
  // never cuts a pulse in half
  always_comb
  begin
    mark_cur_next = mark_cur_reg;
    arb_cur_next  = arb_cur_reg;
    if (period_start)
    begin
      mark_cur_next = tx_mark;
      arb_cur_next  = arb_mode_sel;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      mark_cur_reg <= 1'b0;
      arb_cur_reg  <= 1'b0;
    end
    else
    begin
      mark_cur_reg <= mark_cur_next;
      arb_cur_reg  <= arb_cur_next;
    end
  end

  // ********************************************************
  // stage: pick the segment code, aligned with preset_q
  // ********************************************************
  logic       act_stage_reg;  // pulse active
  logic       act_stage_next;
  logic       arb_stage_reg;  // arbitrary mode
  logic       arb_stage_next;
  logic [2:0] idx_stage_reg;  // segment of the stage
  logic [2:0] idx_stage_next;
  aps_amp_t   amp_stage_reg;  // programmed code
  aps_amp_t   amp_stage_next;

  always_comb
  begin
    // new period values apply from segment one on
    act_stage_next = period_start ? tx_mark : mark_cur_reg;
    arb_stage_next = period_start ? arb_mode_sel : arb_cur_reg;
    idx_stage_next = seg_idx;
    // own registers for segments two to four
    unique case (seg_idx)
      SEG_IDX_TWO:   amp_stage_next = aps_decode(seg_reg[0]);
      SEG_IDX_THREE: amp_stage_next = aps_decode(seg_reg[1]);
      SEG_IDX_FOUR:  amp_stage_next = aps_decode(seg_reg[2]);
      default:       amp_stage_next = other_seg_amp[seg_idx];
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      act_stage_reg <= 1'b0;
      arb_stage_reg <= 1'b0;
      idx_stage_reg <= 3'h0;
      amp_stage_reg <= '0;
    end
    else
    begin
      act_stage_reg <= act_stage_next;
      arb_stage_reg <= arb_stage_next;
      idx_stage_reg <= idx_stage_next;
      amp_stage_reg <= amp_stage_next;
    end
  end

  // ********************************************************
  // driver output
  // ********************************************************
  aps_drive_t drive_next;  // next driver word

  always_comb
  begin
    drive_next.active = act_stage_reg;
    // segments follow the timer in order
    drive_next.seg    = idx_stage_reg;
    if (!act_stage_reg)
      drive_next.amp = '0;                 // space: no pulse
    else if (arb_stage_reg)
      drive_next.amp = amp_stage_reg;
    else
      drive_next.amp = aps_amp_t'(preset_q); // fixed shape
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      drive_reg <= '0;
    else
      drive_reg <= drive_next;
  end

  // ********************************************************
  // checks
  // ********************************************************
  // all checks on ref_clk, quiet during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // a write lands in its own register; an unmapped write changes none of them
  a_seg_two_store: assert property (
    bus.wr && bus.addr == SEG_TWO_ADDR
    |=> rdata_reg == READ_IDLE && seg_reg[0] == $past(bus.wdata))
    else $error("segment two write lost");
  a_seg_three_store: assert property (
    bus.wr && bus.addr == SEG_THREE_ADDR |=> seg_reg[1] == $past(bus.wdata))
    else $error("segment three write lost");
  a_seg_four_store: assert property (
    bus.wr && bus.addr == SEG_FOUR_ADDR |=> seg_reg[2] == $past(bus.wdata))
    else $error("segment four write lost");
  a_wr_unmapped: assert property (
    bus.wr && addr_slot(bus.addr) == 3'b000
    |=> seg_reg[0] == $past(seg_reg[0]) && seg_reg[1] == $past(seg_reg[1])
        && seg_reg[2] == $past(seg_reg[2]))
    else $error("unmapped write changed a register");

  // read data stand in the cycle after the strobe only
  a_seg_three_read: assert property (
    bus.wr && bus.addr == SEG_THREE_ADDR ##1 bus.rd && bus.addr == SEG_THREE_ADDR
    |=> rdata_reg == $past(bus.wdata, 2))
    else $error("segment three readback wrong");
  a_seg_four_read: assert property (
    bus.rd && bus.addr == SEG_FOUR_ADDR |=> rdata_reg == $past(seg_reg[2]))
    else $error("segment four read wrong");
  a_unmapped_read: assert property (
    bus.rd && addr_slot(bus.addr) == 3'b000 |=> rdata_reg == READ_IDLE)
    else $error("unmapped read not zero");
  a_read_idle: assert property (
    !bus.rd |=> rdata_reg == READ_IDLE)
    else $error("read data held too long");

  // programmed codes in arbitrary mode, zero in a space
  a_arb_sign_mag: assert property (
    drive_reg.active && drive_reg.seg == SEG_IDX_TWO && $past(arb_stage_reg)
    |-> drive_reg.amp.sign == $past(seg_reg[0][SIGN_POS], 2)
        && drive_reg.amp.mag == $past(seg_reg[0][MAG_MSB:0], 2))
    else $error("segment two code not applied");
  a_arb_other: assert property (
    drive_reg.active && $past(arb_stage_reg) && drive_reg.seg == 3'h0
    |-> drive_reg.amp == $past(other_seg_amp[0], 2))
    else $error("segment one code not applied");
  a_space_zero: assert property (!drive_reg.active |-> drive_reg.amp == '0)
    else $error("amplitude during space");

  // timer and driver stay in step
  a_seg_order: assert property (
    $changed(drive_reg.seg) |-> drive_reg.seg == $past(drive_reg.seg) + 3'h1)
    else $error("segments out of order");
  a_drive_lag: assert property (
    drive_reg.seg == $past(seg_idx, 2))
    else $error("driver segment not two cycles behind timer");

  // covers of the main scenarios
  c_arb_pulse: cover property (
    drive_reg.active && drive_reg.seg == SEG_IDX_FOUR && $past(arb_stage_reg));
  c_seg_write: cover property (bus.wr && bus.addr == SEG_THREE_ADDR ##1 bus.rd);
  c_preset_pulse: cover property (drive_reg.active && !$past(arb_stage_reg));
  c_space_period: cover property (period_start && !tx_mark);

endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench for the arbitrary pulse segment registers
`timescale 1ns/10ps
`default_nettype none

// compare two values, count the compare, report a mismatch at once
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_top
  import aps_pkg::*;
;

  // ********************************************************
  // settings and signals
  // ********************************************************
  localparam int SC  = 2;              // short segment for a quick run
  localparam int PER = SEG_COUNT * SC; // cycles per master clock period

  // one row of the register table walk
  typedef struct {
    logic [4:0] addr;  // register address
    logic [7:0] data;  // write data
    logic       wr;    // 1 write, 0 read
    logic [7:0] exp;   // expected read data
  } aps_tb_row_t;

  logic           ref_clk;        // 100 MHz clock
  logic           reset_n;        // synchronous reset, active low
  aps_bus_t       bus_s;          // register port
  logic           arb_mode_sel;   // arbitrary mode chosen
  logic           tx_mark;        // pulse wanted
  aps_amp_t [7:0] other_seg_amp;  // codes from neighbour blocks
  logic [7:0]     rdata_reg;      // read data
  aps_drive_t     drive_reg;      // to the line driver
  int             fail_count;     // mismatches seen
  int             n_compared;     // compares made
  logic [7:0]     rd_val;         // last value read
  logic [6:0]     arb_exp [8];    // expected arbitrary shape
  // fixed preset shape as chosen for this design
  logic [6:0]     preset_exp [8] = '{7'h30, 7'h3F, 7'h3C, 7'h38,
                                     7'h48, 7'h44, 7'h42, 7'h00};
  // reset reads, writes incl. unmapped neighbours, read back
  aps_tb_row_t    rows [14] = '{
    '{5'h09, 8'h00, 1'b0, 8'h00}, '{5'h0A, 8'h00, 1'b0, 8'h00},
    '{5'h0B, 8'h00, 1'b0, 8'h00}, '{5'h09, 8'hC5, 1'b1, 8'h00},
    '{5'h0A, 8'h7F, 1'b1, 8'h00}, '{5'h0B, 8'h3A, 1'b1, 8'h00},
    '{5'h08, 8'h55, 1'b1, 8'h00}, '{5'h1F, 8'hAA, 1'b1, 8'h00},
    '{5'h09, 8'h00, 1'b0, 8'hC5}, '{5'h0A, 8'h00, 1'b0, 8'h7F},
    '{5'h0B, 8'h00, 1'b0, 8'h3A}, '{5'h08, 8'h00, 1'b0, 8'h00},
    '{5'h0C, 8'h00, 1'b0, 8'h00}, '{5'h1F, 8'h00, 1'b0, 8'h00}};

  // ********************************************************
  // design under test
  // ********************************************************
  aps_segment_regs #(.SEG_CYCLES(SC)) u_aps_segment_regs (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .bus           (bus_s),
    .arb_mode_sel  (arb_mode_sel),
    .tx_mark       (tx_mark),
    .other_seg_amp (other_seg_amp),
    .rdata_reg     (rdata_reg),
    .drive_reg     (drive_reg)
  );

  // ********************************************************
  // clock and watchdog
  // ********************************************************
  // free running clock, 10 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // cut a hang short, counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("ERROR %0t: run too long", $time);
    wrap_up();
  end

  // ********************************************************
  // tasks
  // ********************************************************
  // verdict and end of run
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one cycle write strobe
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_s <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_s <= '0;
  endtask

  // one cycle read strobe, data taken in the following cycle
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_s <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_s <= '0;
    #1;
    d = rdata_reg;
  endtask

  // wait for segment index to wrap from seven to zero
  task automatic sync_period();
    logic [2:0] prev;
    int         k;
    prev = drive_reg.seg;
    for (k = 0; k < 4 * PER; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (drive_reg.seg === 3'h0 && prev === 3'h7)
        break;
      prev = drive_reg.seg;
    end
    if (k == 4 * PER)
    begin
      fail_count++;
      $display("ERROR %0t: no period start seen", $time);
      wrap_up();
    end
  endtask

  // check one whole period; flip 1 drops mode, 2 drops mark mid period
  task automatic check_period(input logic [6:0] e_tab [8], input logic act,
                              input int flip);
    logic [2:0] s;
    sync_period();
    for (int i = 0; i < PER; i++)
    begin
      s = 3'(i / SC);
      `CHK(drive_reg.seg, s)
      `CHK(drive_reg.active, act)
      `CHK(drive_reg.amp, act ? aps_amp_t'(e_tab[s]) : aps_amp_t'(7'h00))
      if (i < PER - 1)
      begin
        @(posedge ref_clk);
        if (i == 3 && flip == 1)
          arb_mode_sel <= 1'b0;
        if (i == 3 && flip == 2)
          tx_mark <= 1'b0;
        #1;
      end
    end
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    reset_n      = 1'b0;
    bus_s        = '0;
    arb_mode_sel = 1'b0;
    tx_mark      = 1'b0;
    fail_count   = 0;
    n_compared   = 0;
    // distinct neighbour codes, entries 1..3 must be ignored
    for (int j = 0; j < 8; j++)
      other_seg_amp[j] = aps_amp_t'(7'(8'h11 * (j + 1)));
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK(rdata_reg, 8'h00)
    `CHK(drive_reg, aps_drive_t'(0))
    @(posedge ref_clk);
    reset_n <= 1'b1;

    // table walk: reset values, writes, unmapped places, read back
    foreach (rows[r])
    begin
      if (rows[r].wr)
        bus_wr(rows[r].addr, rows[r].data);
      else
      begin
        bus_rd(rows[r].addr, rd_val);
        `CHK(rd_val, rows[r].exp)
      end
    end

    // back to back write, write, read, read, read with no gap
    @(posedge ref_clk);
    bus_s <= '{5'h0B, 8'h5A, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_s <= '{5'h0A, 8'hFF, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_s <= '{5'h0A, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_s <= '{5'h0B, 8'h00, 1'b0, 1'b1};
    #1;
    `CHK(rdata_reg, 8'hFF)
    @(posedge ref_clk);
    bus_s <= '{5'h09, 8'h00, 1'b0, 1'b1};
    #1;
    `CHK(rdata_reg, 8'h5A)
    @(posedge ref_clk);
    bus_s <= '0;
    #1;
    `CHK(rdata_reg, 8'hC5)
    @(posedge ref_clk);
    #1;
    `CHK(rdata_reg, 8'h00)

    // expected arbitrary shape from own registers and neighbours
    foreach (arb_exp[j])
      arb_exp[j] = other_seg_amp[j];
    arb_exp[1] = 7'h45;
    arb_exp[2] = 7'h7F;
    arb_exp[3] = 7'h5A;

    // arbitrary pulse, then preset pulse, then a space
    @(posedge ref_clk);
    arb_mode_sel <= 1'b1;
    tx_mark      <= 1'b1;
    sync_period();
    check_period(arb_exp, 1'b1, 1);
    check_period(preset_exp, 1'b1, 2);
    check_period(preset_exp, 1'b0, 0);

    // second reset in mid run clears registers and output
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(drive_reg, aps_drive_t'(0))
    @(posedge ref_clk);
    reset_n <= 1'b1;
    bus_rd(5'h0A, rd_val);
    `CHK(rd_val, SEG_REG_RESET)
    // timer restarted: driver still idle at segment one
    `CHK(drive_reg, aps_drive_t'(0))
    wrap_up();
  end

endmodule
`default_nettype wire
